//--- common/paof_map.vh
// Register map, field positions and reset values of the port override block.
// Assumes inclusion by bare name from the design files.
`ifndef PAOF_MAP_VH
`define PAOF_MAP_VH

// ****************************************
// Register byte offsets
// ****************************************
`define PAOF_OFF_A_OUT 12'h000
`define PAOF_OFF_A_DIR 12'h004
`define PAOF_OFF_A_SENSE 12'h008
`define PAOF_OFF_B_OUT 12'h00c
`define PAOF_OFF_B_DIR 12'h010
`define PAOF_OFF_B_SENSE 12'h014
`define PAOF_OFF_C_OUT 12'h018
`define PAOF_OFF_C_DIR 12'h01c
`define PAOF_OFF_D_OUT 12'h020
`define PAOF_OFF_D_DIR 12'h024
`define PAOF_OFF_E_OUT 12'h028
`define PAOF_OFF_E_DIR 12'h02c
`define PAOF_OFF_CTRL 12'h030
`define PAOF_OFF_D_SENSE 12'h034
`define PAOF_OFF_E_SENSE 12'h038

// ****************************************
// Control register fields
// ****************************************
`define PAOF_CTRL_EXT_MEM 0
`define PAOF_CTRL_ASYNC_TMR 1
`define PAOF_CTRL_PUD 2
`define PAOF_CTRL_W 3

// ****************************************
// Reset values and widths
// ****************************************
`define PAOF_RST_PORT 8'h00
`define PAOF_RST_PORT_E 3'h0
`define PAOF_RST_CTRL 3'h0
`define PAOF_PORT_W 8
`define PAOF_PORT_E_W 3
`define PAOF_SYNC_W 35

`endif

//--- hw/paof_sync.v
// Two-stage synchroniser for the pad input levels.
// Assumes asynchronous pin levels and one system clock.
module paof_sync #(
    parameter W = 35
) (
    input wire pclk,
    input wire presetn,
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_out
);

    reg [W-1:0] meta_reg;

    // First stage feeds only the second stage
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

//--- hw/paof_top.v
// Pin override and port register block for ports A to E, APB slave.
// Assumes peripheral enables and values arrive on pclk; pads are asynchronous.
//
// Implementation choices: the APB register port and the address map.
`include "paof_map.vh"

module paof_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [7:0] pad_a_in,
    output reg [7:0] pad_a_out,
    output reg [7:0] pad_a_oe,
    output reg [7:0] pad_a_pu,
    input wire [7:0] pad_b_in,
    output reg [7:0] pad_b_out,
    output reg [7:0] pad_b_oe,
    output reg [7:0] pad_b_pu,
    input wire [7:0] pad_c_in,
    output reg [7:0] pad_c_out,
    output reg [7:0] pad_c_oe,
    output reg [7:0] pad_c_pu,
    input wire [7:0] pad_d_in,
    output reg [7:0] pad_d_out,
    output reg [7:0] pad_d_oe,
    output reg [7:0] pad_d_pu,
    output reg [7:0] pad_d_ie,
    input wire [2:0] pad_e_in,
    output reg [2:0] pad_e_out,
    output reg [2:0] pad_e_oe,
    output reg [2:0] pad_e_pu,
    output reg [2:0] pad_e_ie,
    input wire ext_read_strobe,
    input wire ext_store_strobe,
    input wire addr_latch_strobe,
    input wire t1_cmp_a_en,
    input wire t1_cmp_a_out,
    input wire t1_cmp_b_en,
    input wire t1_cmp_b_out,
    input wire t3_cmp_a_en,
    input wire t3_cmp_a_out,
    input wire serial0_ext_clk_oe,
    input wire serial0_ext_clk_out,
    input wire serial1_ext_clk_oe,
    input wire serial1_ext_clk_out,
    input wire serial0_tx_enable,
    input wire serial0_tx_line,
    input wire serial0_rx_enable,
    input wire ext_irq0_en,
    input wire ext_irq1_en,
    input wire ext_irq2_en,
    output reg serial0_rx_line,
    output reg serial0_ext_clk_in,
    output reg serial1_ext_clk_in,
    output reg ext_irq0_in,
    output reg ext_irq1_in,
    output reg ext_irq2_in,
    output reg t1_capture_in,
    output reg t3_capture_in,
    output reg ext_mem_enable,
    output reg async_timer_clock_sel
);

    // ****************************************
    // Software registers
    // ****************************************
    reg [7:0] port_a_output_reg;
    reg [7:0] port_a_direction_reg;
    reg [7:0] port_b_output_reg;
    reg [7:0] port_b_direction_reg;
    reg [7:0] port_c_output_reg;
    reg [7:0] port_c_direction_reg;
    reg [7:0] port_d_output_reg;
    reg [7:0] port_d_direction_reg;
    reg [2:0] port_e_output_reg;
    reg [2:0] port_e_direction_reg;
    reg [`PAOF_CTRL_W-1:0] ctrl_reg;

    wire ext_mem_en = ctrl_reg[`PAOF_CTRL_EXT_MEM];
    wire async_sel = ctrl_reg[`PAOF_CTRL_ASYNC_TMR];
    wire global_pullup_disable = ctrl_reg[`PAOF_CTRL_PUD];
    wire portd_bit0_out = port_d_output_reg[0];

    // ****************************************
    // Pad synchronisation
    // ****************************************
    wire [34:0] sync_pins;

    paof_sync #(
        .W(`PAOF_SYNC_W)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({pad_e_in, pad_d_in, pad_c_in, pad_b_in, pad_a_in}),
        .sync_out(sync_pins)
    );

    wire [7:0] sense_a = sync_pins[7:0];
    wire [7:0] sense_b = sync_pins[15:8];
    wire [7:0] sense_c = sync_pins[23:16];
    wire [7:0] raw_d = sync_pins[31:24];
    wire [2:0] raw_e = sync_pins[34:32];

    // ****************************************
    // Override vectors, ports D and E
    // ****************************************
    reg [10:0] pullup_override_en;
    reg [10:0] pullup_override_val;
    reg [10:0] dir_override_en;
    reg [10:0] dir_override_val;
    reg [10:0] value_override_en;
    reg [10:0] value_override_val;
    reg [10:0] input_en_override_en;
    reg [10:0] input_en_override_val;

    always @* begin
        pullup_override_en = 11'h000;
        pullup_override_val = 11'h000;
        dir_override_en = 11'h000;
        dir_override_val = 11'h000;
        value_override_en = 11'h000;
        value_override_val = 11'h000;
        input_en_override_en = 11'h000;
        input_en_override_val = 11'h000;
        // Memory strobes on D7 and D6
        pullup_override_en[7] = ext_mem_en;
        pullup_override_en[6] = ext_mem_en;
        dir_override_en[7] = ext_mem_en;
        dir_override_en[6] = ext_mem_en;
        dir_override_val[7] = 1'b1;
        dir_override_val[6] = 1'b1;
        value_override_en[7] = ext_mem_en;
        value_override_en[6] = ext_mem_en;
        value_override_val[7] = ext_read_strobe;
        value_override_val[6] = ext_store_strobe;
        // Oscillator pins lose drive, pull-up and digital input; their output value is left to the compares and the serial0 clock
        pullup_override_en[5] = async_sel;
        pullup_override_en[4] = async_sel;
        dir_override_en[5] = async_sel;
        dir_override_en[4] = async_sel;
        input_en_override_en[5] = async_sel;
        input_en_override_en[4] = async_sel;
        value_override_en[5] = t1_cmp_a_en;
        value_override_val[5] = t1_cmp_a_out;
        value_override_en[4] = serial0_ext_clk_oe | t3_cmp_a_en;
        value_override_val[4] = serial0_ext_clk_oe ?
            serial0_ext_clk_out : t3_cmp_a_out;
        // Interrupt inputs stay readable even when driven as outputs
        input_en_override_en[3] = ext_irq1_en;
        input_en_override_val[3] = 1'b1;
        input_en_override_en[2] = ext_irq0_en;
        input_en_override_val[2] = 1'b1;
        value_override_en[2] = serial1_ext_clk_oe;
        value_override_val[2] = serial1_ext_clk_out;
        // Serial0 transmit and receive
        pullup_override_en[1] = serial0_tx_enable;
        dir_override_en[1] = serial0_tx_enable;
        dir_override_val[1] = 1'b1;
        value_override_en[1] = serial0_tx_enable;
        value_override_val[1] = serial0_tx_line;
        pullup_override_en[0] = serial0_rx_enable;
        pullup_override_val[0] = portd_bit0_out & ~global_pullup_disable;
        dir_override_en[0] = serial0_rx_enable;
        // Port E, index 8 is E0
        input_en_override_en[8] = ext_irq2_en;
        input_en_override_val[8] = 1'b1;
        pullup_override_en[9] = ext_mem_en;
        dir_override_en[9] = ext_mem_en;
        dir_override_val[9] = 1'b1;
        value_override_en[9] = ext_mem_en;
        value_override_val[9] = addr_latch_strobe;
        // Direction left to software so the compare needs DDR set
        value_override_en[10] = t1_cmp_b_en;
        value_override_val[10] = t1_cmp_b_out;
    end

    // ****************************************
    // Per-pin resolution, ports D and E
    // ****************************************
    wire [10:0] soft_out = {port_e_output_reg, port_d_output_reg};
    wire [10:0] soft_dir = {port_e_direction_reg, port_d_direction_reg};
    wire [10:0] pin_pu;
    wire [10:0] pin_oe;
    wire [10:0] pin_val;
    wire [10:0] pin_ie;

    genvar gi;
    generate
        for (gi = 0; gi < 11; gi = gi + 1) begin : g_pin
            wire soft_pu = soft_out[gi] & ~soft_dir[gi] & ~global_pullup_disable;
            assign pin_pu[gi] = pullup_override_en[gi] ?
                pullup_override_val[gi] : soft_pu;
            assign pin_oe[gi] = dir_override_en[gi] ?
                dir_override_val[gi] : soft_dir[gi];
            assign pin_val[gi] = value_override_en[gi] ?
                value_override_val[gi] : soft_out[gi];
            assign pin_ie[gi] = input_en_override_en[gi] ?
                input_en_override_val[gi] : 1'b1;
        end
    endgenerate

    // Disabled digital inputs read as zero
    wire [7:0] sense_d = raw_d & pin_ie[7:0];
    wire [2:0] sense_e = raw_e & pin_ie[10:8];

    // ****************************************
    // Registered pad and peripheral outputs
    // ****************************************
    wire [7:0] pu_abc_dis = {8{global_pullup_disable}};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_a_out <= 8'h00;
            pad_a_oe <= 8'h00;
            pad_a_pu <= 8'h00;
            pad_b_out <= 8'h00;
            pad_b_oe <= 8'h00;
            pad_b_pu <= 8'h00;
            pad_c_out <= 8'h00;
            pad_c_oe <= 8'h00;
            pad_c_pu <= 8'h00;
            pad_d_out <= 8'h00;
            pad_d_oe <= 8'h00;
            pad_d_pu <= 8'h00;
            pad_d_ie <= 8'hff;
            pad_e_out <= 3'h0;
            pad_e_oe <= 3'h0;
            pad_e_pu <= 3'h0;
            pad_e_ie <= 3'h7;
            serial0_rx_line <= 1'b0;
            serial0_ext_clk_in <= 1'b0;
            serial1_ext_clk_in <= 1'b0;
            ext_irq0_in <= 1'b0;
            ext_irq1_in <= 1'b0;
            ext_irq2_in <= 1'b0;
            t1_capture_in <= 1'b0;
            t3_capture_in <= 1'b0;
            ext_mem_enable <= 1'b0;
            async_timer_clock_sel <= 1'b0;
        end else begin
            pad_a_out <= port_a_output_reg;
            pad_a_oe <= port_a_direction_reg;
            pad_a_pu <= port_a_output_reg & ~port_a_direction_reg & ~pu_abc_dis;
            pad_b_out <= port_b_output_reg;
            pad_b_oe <= port_b_direction_reg;
            pad_b_pu <= port_b_output_reg & ~port_b_direction_reg & ~pu_abc_dis;
            pad_c_out <= port_c_output_reg;
            pad_c_oe <= port_c_direction_reg;
            pad_c_pu <= port_c_output_reg & ~port_c_direction_reg & ~pu_abc_dis;
            pad_d_out <= pin_val[7:0];
            pad_d_oe <= pin_oe[7:0];
            pad_d_pu <= pin_pu[7:0];
            pad_d_ie <= pin_ie[7:0];
            pad_e_out <= pin_val[10:8];
            pad_e_oe <= pin_oe[10:8];
            pad_e_pu <= pin_pu[10:8];
            pad_e_ie <= pin_ie[10:8];
            serial0_rx_line <= sense_d[0];
            serial1_ext_clk_in <= sense_d[2];
            ext_irq0_in <= sense_d[2];
            ext_irq1_in <= sense_d[3];
            t3_capture_in <= sense_d[3];
            serial0_ext_clk_in <= sense_d[4];
            ext_irq2_in <= sense_e[0];
            t1_capture_in <= sense_e[0];
            ext_mem_enable <= ext_mem_en;
            async_timer_clock_sel <= async_sel;
        end
    end

    // ****************************************
    // APB slave
    // ****************************************
    // Answer is prepared in setup, so every access completes with no wait state
    wire setup_ph = psel & ~penable;
    wire wr_take = psel & penable & pready & pwrite;
    wire [31:0] wd = pwdata;
    reg [31:0] rd_next;
    reg err_next;

    always @* begin
        rd_next = 32'h0000_0000;
        err_next = 1'b0;
        case (paddr)
            `PAOF_OFF_A_OUT: rd_next[7:0] = port_a_output_reg;
            `PAOF_OFF_A_DIR: rd_next[7:0] = port_a_direction_reg;
            `PAOF_OFF_A_SENSE: rd_next[7:0] = sense_a;
            `PAOF_OFF_B_OUT: rd_next[7:0] = port_b_output_reg;
            `PAOF_OFF_B_DIR: rd_next[7:0] = port_b_direction_reg;
            `PAOF_OFF_B_SENSE: rd_next[7:0] = sense_b;
            `PAOF_OFF_C_OUT: rd_next[7:0] = port_c_output_reg;
            `PAOF_OFF_C_DIR: rd_next[7:0] = port_c_direction_reg;
            `PAOF_OFF_D_OUT: rd_next[7:0] = port_d_output_reg;
            `PAOF_OFF_D_DIR: rd_next[7:0] = port_d_direction_reg;
            `PAOF_OFF_E_OUT: rd_next[2:0] = port_e_output_reg;
            `PAOF_OFF_E_DIR: rd_next[2:0] = port_e_direction_reg;
            `PAOF_OFF_CTRL: rd_next[`PAOF_CTRL_W-1:0] = ctrl_reg;
            `PAOF_OFF_D_SENSE: rd_next[7:0] = sense_d;
            `PAOF_OFF_E_SENSE: rd_next[2:0] = sense_e;
            default: err_next = 1'b1;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (setup_ph) begin
            pready <= 1'b1;
            pslverr <= err_next;
            prdata <= pwrite ? 32'h0000_0000 : rd_next;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
    end

    // Sense registers ignore writes; an unmapped write only raises pslverr
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_a_output_reg <= `PAOF_RST_PORT;
            port_a_direction_reg <= `PAOF_RST_PORT;
            port_b_output_reg <= `PAOF_RST_PORT;
            port_b_direction_reg <= `PAOF_RST_PORT;
            port_c_output_reg <= `PAOF_RST_PORT;
            port_c_direction_reg <= `PAOF_RST_PORT;
            port_d_output_reg <= `PAOF_RST_PORT;
            port_d_direction_reg <= `PAOF_RST_PORT;
            port_e_output_reg <= `PAOF_RST_PORT_E;
            port_e_direction_reg <= `PAOF_RST_PORT_E;
            ctrl_reg <= `PAOF_RST_CTRL;
        end else if (wr_take) begin
            case (paddr)
                `PAOF_OFF_A_OUT: port_a_output_reg <= wd[7:0];
                `PAOF_OFF_A_DIR: port_a_direction_reg <= wd[7:0];
                `PAOF_OFF_B_OUT: port_b_output_reg <= wd[7:0];
                `PAOF_OFF_B_DIR: port_b_direction_reg <= wd[7:0];
                `PAOF_OFF_C_OUT: port_c_output_reg <= wd[7:0];
                `PAOF_OFF_C_DIR: port_c_direction_reg <= wd[7:0];
                `PAOF_OFF_D_OUT: port_d_output_reg <= wd[7:0];
                `PAOF_OFF_D_DIR: port_d_direction_reg <= wd[7:0];
                `PAOF_OFF_E_OUT: port_e_output_reg <= wd[2:0];
                `PAOF_OFF_E_DIR: port_e_direction_reg <= wd[2:0];
                `PAOF_OFF_CTRL: ctrl_reg <= wd[`PAOF_CTRL_W-1:0];
                default: ctrl_reg <= ctrl_reg;
            endcase
        end
    end

endmodule

//--- sim/paof_assertions.sv
// Port-level checks of the pin override block.
// Assumes peripheral inputs are held low while reset is asserted.
module paof_chk (
    input wire pclk, presetn, psel, penable, pready, pslverr,
    input wire [31:0] prdata,
    input wire [7:0] pad_d_out, pad_d_oe, pad_d_pu, pad_d_ie,
    input wire [2:0] pad_e_out, pad_e_oe, pad_e_pu, pad_e_ie,
    input wire ext_read_strobe, ext_store_strobe, addr_latch_strobe,
    input wire t1_cmp_a_en, t1_cmp_a_out, t1_cmp_b_en, t1_cmp_b_out, t3_cmp_a_en, t3_cmp_a_out,
    input wire serial0_ext_clk_oe, serial0_ext_clk_out, serial1_ext_clk_oe, serial1_ext_clk_out,
    input wire serial0_tx_enable, serial0_tx_line, serial0_rx_enable,
    input wire ext_irq0_en, ext_irq1_en, ext_irq2_en, ext_mem_enable, async_timer_clock_sel
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rx; $past(serial0_rx_enable) |-> !pad_d_oe[0]; endproperty
    a_rx: assert property (p_rx) else $error("rx pin driven");
    // Mode bit held two cycles, so pad and copy flops agree
    property p_mem_d; ext_mem_enable && $past(ext_mem_enable) |-> pad_d_oe[7:6] == 2'b11
        && pad_d_pu[7:6] == 2'b00 && pad_d_out[7:6] == {$past(ext_read_strobe),
        $past(ext_store_strobe)}; endproperty
    a_mem_d: assert property (p_mem_d) else $error("strobe pins wrong");
    property p_osc; async_timer_clock_sel && $past(async_timer_clock_sel) |->
        {pad_d_oe[5:4], pad_d_pu[5:4], pad_d_ie[5:4]} == 6'h00; endproperty
    a_osc: assert property (p_osc) else $error("osc pins not detached");
    property p_d5; $past(t1_cmp_a_en) |-> pad_d_out[5] == $past(t1_cmp_a_out); endproperty
    a_d5: assert property (p_d5) else $error("d5 value wrong");
    property p_d4; $past(serial0_ext_clk_oe) || $past(t3_cmp_a_en) |-> pad_d_out[4] ==
        ($past(serial0_ext_clk_oe) ? $past(serial0_ext_clk_out) : $past(t3_cmp_a_out));
    endproperty
    a_d4: assert property (p_d4) else $error("d4 value wrong");
    property p_tx; $past(serial0_tx_enable) |-> pad_d_oe[1] && !pad_d_pu[1]
        && pad_d_out[1] == $past(serial0_tx_line); endproperty
    a_tx: assert property (p_tx) else $error("tx pin wrong");
    property p_irq; (pad_d_ie[3:2] & {$past(ext_irq1_en), $past(ext_irq0_en)}) ==
        {$past(ext_irq1_en), $past(ext_irq0_en)}; endproperty
    a_irq: assert property (p_irq) else $error("irq input disabled");
    property p_d2; $past(serial1_ext_clk_oe) |-> pad_d_out[2] == $past(serial1_ext_clk_out);
    endproperty
    a_d2: assert property (p_d2) else $error("d2 value wrong");
    property p_ale; ext_mem_enable && $past(ext_mem_enable) |-> pad_e_oe[1] && !pad_e_pu[1]
        && pad_e_out[1] == $past(addr_latch_strobe); endproperty
    a_ale: assert property (p_ale) else $error("latch strobe pin wrong");
    property p_e2; $past(t1_cmp_b_en) |-> pad_e_out[2] == $past(t1_cmp_b_out); endproperty
    a_e2: assert property (p_e2) else $error("e2 value wrong");
    property p_e0; $past(ext_irq2_en) |-> pad_e_ie[0]; endproperty
    a_e0: assert property (p_e0) else $error("e0 input disabled");
    property p_rdy; psel && !penable ##1 psel && penable |-> pready ##1 !pready; endproperty
    a_rdy: assert property (p_rdy) else $error("access not answered at once");
    property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("error reply carries data");
endmodule

bind paof_top paof_chk paof_chk_inst (.*);

//--- sim/paof_pin_model.sv
// Pad model: resolves each pin from pad drive, outside drive and pull-up.
// Assumes the bench never drives a pin that the block drives.
module paof_pin_model #(parameter int W = 8) (
    input wire pclk,
    input wire [W-1:0] out, oe, pu, ext_en, ext_val,
    output wire [W-1:0] level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic flt = 1'b0;
    always @(posedge pclk) flt <= ~flt;
    // A floating pin wanders, so no test can lean on a stale level
    assign level = (oe & out) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & (pu | {W{flt}}));
endmodule

//--- sim/paof_top_tb.sv
// Self-checking bench for the pin override block, APB register access.
// Assumes the register map header and the pad model.
`include "paof_map.vh"
module paof_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, rd;
    wire [31:0] prdata;
    wire pready, pslverr;
    wire [7:0] pad_a_in, pad_a_out, pad_a_oe, pad_a_pu, pad_b_in, pad_b_out, pad_b_oe, pad_b_pu;
    wire [7:0] pad_c_in, pad_c_out, pad_c_oe, pad_c_pu;
    wire [7:0] pad_d_in, pad_d_out, pad_d_oe, pad_d_pu, pad_d_ie;
    wire [2:0] pad_e_in, pad_e_out, pad_e_oe, pad_e_pu, pad_e_ie;
    logic ext_read_strobe = 0, ext_store_strobe = 0, addr_latch_strobe = 0, t1_cmp_a_en = 0;
    logic t1_cmp_a_out = 0, t1_cmp_b_en = 0, t1_cmp_b_out = 0, t3_cmp_a_en = 0, t3_cmp_a_out = 0;
    logic serial0_ext_clk_oe = 0, serial0_ext_clk_out = 0, serial1_ext_clk_oe = 0;
    logic serial1_ext_clk_out = 0, serial0_tx_enable = 0, serial0_tx_line = 0;
    logic serial0_rx_enable = 0, ext_irq0_en = 0, ext_irq1_en = 0, ext_irq2_en = 0;
    wire serial0_rx_line, serial0_ext_clk_in, serial1_ext_clk_in, ext_irq0_in, ext_irq1_in;
    wire ext_irq2_in, t1_capture_in, t3_capture_in, ext_mem_enable, async_timer_clock_sel;
    logic [7:0] xa_en = '0, xa_v = '0, xb_en = '0, xb_v = '0, xc_en = '0, xc_v = '0;
    logic [7:0] xd_en = '0, xd_v = '0;
    logic [2:0] xe_en = '0, xe_v = '0;
    int miscompares = 0, num_checks = 0, cyc = 0;
    logic [11:0] offs [11] = '{`PAOF_OFF_A_OUT, `PAOF_OFF_A_DIR, `PAOF_OFF_B_OUT,
        `PAOF_OFF_B_DIR, `PAOF_OFF_C_OUT, `PAOF_OFF_C_DIR, `PAOF_OFF_D_OUT, `PAOF_OFF_D_DIR,
        `PAOF_OFF_E_OUT, `PAOF_OFF_E_DIR, `PAOF_OFF_CTRL};
    logic [3:0] d4c [4] = '{4'b1101, 4'b0111, 4'b1010, 4'b0011};
    logic [3:0] d4x = 4'b0110;

    paof_top paof_top_inst (.*);
    paof_pin_model #(.W(8)) pin_a (.pclk(pclk), .out(pad_a_out), .oe(pad_a_oe), .pu(pad_a_pu),
        .ext_en(xa_en), .ext_val(xa_v), .level(pad_a_in));
    paof_pin_model #(.W(8)) pin_b (.pclk(pclk), .out(pad_b_out), .oe(pad_b_oe), .pu(pad_b_pu),
        .ext_en(xb_en), .ext_val(xb_v), .level(pad_b_in));
    paof_pin_model #(.W(8)) pin_c (.pclk(pclk), .out(pad_c_out), .oe(pad_c_oe), .pu(pad_c_pu),
        .ext_en(xc_en), .ext_val(xc_v), .level(pad_c_in));
    paof_pin_model #(.W(8)) pin_d (.pclk(pclk), .out(pad_d_out), .oe(pad_d_oe), .pu(pad_d_pu),
        .ext_en(xd_en), .ext_val(xd_v), .level(pad_d_in));
    paof_pin_model #(.W(3)) pin_e (.pclk(pclk), .out(pad_e_out), .oe(pad_e_oe), .pu(pad_e_pu),
        .ext_en(xe_en), .ext_val(xe_v), .level(pad_e_in));

    always #5 pclk = ~pclk;

    task print_verdict;
        if (miscompares == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            print_verdict;
        end
    end

    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Request held until pready is seen high at a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            miscompares++;
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask

    task settle;
        repeat (5) @(posedge pclk);
        @(negedge pclk);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        foreach (offs[i]) rdc("reset value", offs[i], 32'h0);
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, offs[i], {24'hffffff, 8'h3c ^ 8'(i * 17)});
            rdc("readback", offs[i], {24'h0, 8'h3c ^ 8'(i * 17)});
        end
        apb(1'b1, `PAOF_OFF_A_OUT, 32'ha5);
        apb(1'b1, `PAOF_OFF_A_DIR, 32'h0f);
        @(posedge pclk);
        xa_en <= 8'hf0;
        xa_v <= 8'h3c;
        settle;
        chk("a pins", {pad_a_out, pad_a_oe, pad_a_pu}, 24'ha50fa0);
        chk("b pins", {pad_b_out, pad_b_oe, pad_b_pu}, 24'h1e0f10);
        chk("c pins", {pad_c_out, pad_c_oe, pad_c_pu}, 24'h786910);
        rdc("a sense", `PAOF_OFF_A_SENSE, 32'h35);
        apb(1'b1, `PAOF_OFF_A_SENSE, 32'hff);
        rdc("a sense kept", `PAOF_OFF_A_SENSE, 32'h35);
        apb(1'b0, 12'h03c, 32'h0);
        chk("unmapped err", err, 1'b1);
        chk("unmapped data", rd, 32'h0);
        apb(1'b1, `PAOF_OFF_D_OUT, 32'h01);
        apb(1'b1, `PAOF_OFF_D_DIR, 32'h01);
        @(posedge pclk);
        serial0_rx_enable <= 1;
        settle;
        chk("rx pin", {pad_d_oe[0], pad_d_pu[0], serial0_rx_line}, 3'b011);
        apb(1'b1, `PAOF_OFF_CTRL, 32'h4);
        settle;
        chk("rx pull off", pad_d_pu[0], 1'b0);
        apb(1'b1, `PAOF_OFF_D_OUT, 32'hff);
        apb(1'b1, `PAOF_OFF_D_DIR, 32'h00);
        apb(1'b1, `PAOF_OFF_E_OUT, 32'h7);
        apb(1'b1, `PAOF_OFF_CTRL, 32'h1);
        @(posedge pclk);
        ext_read_strobe <= 1;
        addr_latch_strobe <= 1;
        settle;
        chk("d7 d6", {pad_d_oe[7:6], pad_d_pu[7:6], pad_d_out[7:6], pad_d_ie[7:6]}, 8'hcb);
        chk("e1", {pad_e_oe[1], pad_e_pu[1], pad_e_out[1], ext_mem_enable}, 4'hb);
        apb(1'b1, `PAOF_OFF_D_DIR, 32'hff);
        apb(1'b1, `PAOF_OFF_CTRL, 32'h2);
        settle;
        chk("osc pins", {pad_d_oe[5:4], pad_d_pu[5:4], pad_d_ie[5:4]}, 6'h00);
        chk("osc sel", {async_timer_clock_sel, ext_mem_enable}, 2'b10);
        apb(1'b1, `PAOF_OFF_CTRL, 32'h0);
        apb(1'b1, `PAOF_OFF_D_OUT, 32'h00);
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            t1_cmp_a_en <= 1;
            t1_cmp_a_out <= 1;
            {serial0_ext_clk_oe, t3_cmp_a_en, serial0_ext_clk_out, t3_cmp_a_out} <= d4c[i];
            settle;
            chk("d5 d4", {pad_d_out[5:4], serial0_ext_clk_in}, {1'b1, d4x[i], d4x[i]});
        end
        apb(1'b1, `PAOF_OFF_D_OUT, 32'h06);
        apb(1'b1, `PAOF_OFF_D_DIR, 32'h00);
        @(posedge pclk);
        serial0_tx_enable <= 1;
        ext_irq0_en <= 1;
        ext_irq1_en <= 1;
        ext_irq2_en <= 1;
        serial1_ext_clk_oe <= 1;
        xd_en <= 8'h08;
        xd_v <= 8'h08;
        xe_en <= 3'h1;
        xe_v <= 3'h1;
        settle;
        chk("tx pin", {pad_d_oe[1], pad_d_pu[1], pad_d_out[1]}, 3'b100);
        chk("d2", {pad_d_out[2], pad_d_oe[2], pad_d_pu[2], pad_d_ie[3:2]}, 5'h07);
        chk("irq in", {ext_irq0_in, ext_irq1_in, t3_capture_in, serial1_ext_clk_in}, 4'hf);
        chk("e0", {pad_e_ie[0], ext_irq2_in, t1_capture_in}, 3'b111);
        apb(1'b1, `PAOF_OFF_E_DIR, 32'h4);
        apb(1'b1, `PAOF_OFF_E_OUT, 32'h0);
        @(posedge pclk);
        t1_cmp_b_en <= 1;
        t1_cmp_b_out <= 1;
        settle;
        chk("e2", {pad_e_oe[2], pad_e_out[2], pad_e_pu[2]}, 3'b110);
        print_verdict;
    end
endmodule
